// *** include/ppfm_map.vh ***
// Purpose: Named constants for the port pin function multiplexer
// Assumes: Included by every design file of the block
// Notes:   Masks are 8 bits wide; narrower ports use the low bits
`ifndef PPFM_MAP_VH
`define PPFM_MAP_VH

// Port widths
`define PPFM_RX_W          8
`define PPFM_TX_W          7
`define PPFM_MG_W          4
`define PPFM_VEC_W         8

// Glitch filter: samples a level must hold before it is believed
`define PPFM_FILT_CNT_W    2
`define PPFM_FILT_CYCLES   2'h3
`define PPFM_FILT_ZERO     2'h0
`define PPFM_FILT_ONE      2'h1

// Pins owned by the media interface when it is selected
`define PPFM_RX_OWN_MASK   8'h7F
`define PPFM_TX_OWN_MASK   8'h7F
`define PPFM_MG_OWN_MASK   8'h0F
// Pins the media interface drives while it owns them
`define PPFM_RX_PER_OE     8'h00
`define PPFM_TX_PER_OE     8'h6F
`define PPFM_MG_PER_OE_FIX 8'h01

// Receive-side bit positions
`define PPFM_RX_ER_BIT     6
`define PPFM_RX_DV_BIT     5
`define PPFM_RX_CLK_BIT    4
// Transmit-side bit positions
`define PPFM_TX_CLK_BIT    4
// Management-side bit positions
`define PPFM_MG_COL_BIT    3
`define PPFM_MG_CRS_BIT    2
`define PPFM_MG_MDIO_BIT   1

// Reset values
`define PPFM_ZERO8         8'h00
`define PPFM_ZERO4         4'h0
`define PPFM_ZERO7         7'h00

`endif

// *** logic/ppfm_irq_filter.v ***
// Purpose: Per-port glitch filter and sticky wake-up interrupt flags
// Assumes: Pin samples are synchronous to sys_clk
// Notes:   Active edge follows pull polarity: falling with pull-up, rising with pull-down
`timescale 1ns/1ps
`include "ppfm_map.vh"

module ppfm_irq_filter #(
  parameter W = 8
) (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire [W-1:0] pin_raw,
  input  wire [W-1:0] pull_up,
  input  wire [W-1:0] irq_en,
  input  wire [W-1:0] flag_clr,
  output reg  [W-1:0] flag,
  output reg          irq
);

  reg  [W-1:0]                  filt;     // Filtered pin level
  reg  [`PPFM_FILT_CNT_W*W-1:0] cnt;      // Disagreement counters, one per pin
  reg  [W-1:0]                  next_filt;
  reg  [`PPFM_FILT_CNT_W*W-1:0] next_cnt;
  reg  [W-1:0]                  edge_hit; // Qualified active edge this cycle
  reg  [`PPFM_FILT_CNT_W-1:0]   c;
  integer                       i;

  // Filter: a level must differ for a full run before it is taken
  always @* begin
    next_filt = filt;
    next_cnt  = cnt;
    edge_hit  = {W{1'b0}};
    c         = `PPFM_FILT_ZERO;
    for (i = 0; i < W; i = i + 1) begin
      c = cnt[i*`PPFM_FILT_CNT_W +: `PPFM_FILT_CNT_W];
      if (pin_raw[i] == filt[i]) begin
        // Short pulse ends; start over
        c = `PPFM_FILT_ZERO;
      end else if (c == `PPFM_FILT_CYCLES - `PPFM_FILT_ONE) begin
        // Stable long enough: accept new level
        next_filt[i] = pin_raw[i];
        c            = `PPFM_FILT_ZERO;
        // Active edge: new level opposite the pull, so a pulled idle pin never flags
        edge_hit[i]  = irq_en[i] & (pin_raw[i] ^ pull_up[i]);
      end else begin
        c = c + `PPFM_FILT_ONE;
      end
      next_cnt[i*`PPFM_FILT_CNT_W +: `PPFM_FILT_CNT_W] = c;
    end
  end

  // Flags: set wins over a clear in the same cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      filt <= {W{1'b0}};
      cnt  <= {`PPFM_FILT_CNT_W*W{1'b0}};
      flag <= {W{1'b0}};
      irq  <= 1'b0;
    end else begin
      filt <= next_filt;
      cnt  <= next_cnt;
      flag <= (flag & ~flag_clr) | edge_hit;
      irq  <= |(((flag & ~flag_clr) | edge_hit) & irq_en);
    end
  end

endmodule // ppfm_irq_filter

// *** logic/ppfm_port_mux.v ***
// Purpose: Pin function multiplexer for the three media-interface ports
// Assumes: Single clock; all inputs synchronous to sys_clk; pad cells outside
// Notes:   Media interface outranks general I/O; wake-up sees the pins whoever owns them; every output is registered

`timescale 1ns/1ps
`include "ppfm_map.vh"

module ppfm_port_mux (
  input  wire       sys_clk,
  input  wire       rst,
  // Receive-side port: pad and configuration
  input  wire [7:0] rx_pin_in,
  output reg  [7:0] rx_pin_out,
  output reg  [7:0] rx_pin_oe,
  output reg  [7:0] rx_pad_reduce,
  output reg  [7:0] rx_pad_pull_en,
  output reg  [7:0] rx_pad_pull_up,
  output reg  [7:0] rx_pin_value,
  input  wire       rx_mii_sel,
  input  wire [7:0] rx_gpio_data,
  input  wire [7:0] rx_gpio_dir,
  input  wire [7:0] rx_reduce_cfg,
  input  wire [7:0] rx_pull_en_cfg,
  input  wire [7:0] rx_pull_up_cfg,
  input  wire [7:0] rx_open_drain_cfg,
  input  wire [7:0] rx_irq_en,
  input  wire [7:0] rx_flag_clr,
  output wire [7:0] rx_irq_flag,
  output wire       rx_irq,
  // Transmit-side port
  input  wire [6:0] tx_pin_in,
  output reg  [6:0] tx_pin_out,
  output reg  [6:0] tx_pin_oe,
  output reg  [6:0] tx_pad_reduce,
  output reg  [6:0] tx_pad_pull_en,
  output reg  [6:0] tx_pad_pull_up,
  output reg  [6:0] tx_pin_value,
  input  wire       tx_mii_sel,
  input  wire [6:0] tx_gpio_data,
  input  wire [6:0] tx_gpio_dir,
  input  wire [6:0] tx_reduce_cfg,
  input  wire [6:0] tx_pull_en_cfg,
  input  wire [6:0] tx_pull_up_cfg,
  input  wire [6:0] tx_open_drain_cfg,
  input  wire [6:0] tx_irq_en,
  input  wire [6:0] tx_flag_clr,
  output wire [6:0] tx_irq_flag,
  output wire       tx_irq,
  // Management-side port
  input  wire [3:0] mg_pin_in,
  output reg  [3:0] mg_pin_out,
  output reg  [3:0] mg_pin_oe,
  output reg  [3:0] mg_pad_reduce,
  output reg  [3:0] mg_pad_pull_en,
  output reg  [3:0] mg_pad_pull_up,
  output reg  [3:0] mg_pin_value,
  input  wire       mg_mii_sel,
  input  wire [3:0] mg_gpio_data,
  input  wire [3:0] mg_gpio_dir,
  input  wire [3:0] mg_reduce_cfg,
  input  wire [3:0] mg_pull_en_cfg,
  input  wire [3:0] mg_pull_up_cfg,
  input  wire [3:0] mg_open_drain_cfg,
  input  wire [3:0] mg_irq_en,
  input  wire [3:0] mg_flag_clr,
  output wire [3:0] mg_irq_flag,
  output wire       mg_irq,
  // Ethernet controller side
  output reg  [3:0] mac_rxd,
  output reg        mac_rx_dv,
  output reg        mac_rx_er,
  output reg        mac_rx_clk,
  input  wire [3:0] mac_txd,
  input  wire       mac_tx_en,
  input  wire       mac_tx_er,
  output reg        mac_tx_clk,
  output reg        mac_col,
  output reg        mac_crs,
  output reg        mac_mdio_in,
  input  wire       mac_mdio_out,
  input  wire       mac_mdio_oe,
  input  wire       mac_mdc
);

  // Resolve one port: returns {oe, out}; peripheral bits override GPIO
  function [15:0] resolve;
    input [7:0] own;    // Bits owned by the peripheral
    input [7:0] p_out;  // Peripheral data
    input [7:0] p_oe;   // Peripheral enable
    input [7:0] g_data; // General I/O data
    input [7:0] g_dir;  // General I/O direction, 1 = output
    input [7:0] od;     // Open-drain select
    reg   [7:0] o;
    reg   [7:0] e;
    begin
      o = (own & p_out) | (~own & g_data);
      e = (own & p_oe)  | (~own & g_dir);
      // Open drain: only low is driven, high releases the line
      e = e & ~(od & o);
      o = o & ~od;
      resolve = {e, o};
    end
  endfunction

  wire [7:0]  rx_own;  // Ownership masks from the selects
  wire [7:0]  tx_own;
  wire [7:0]  mg_own;
  wire [15:0] rx_res;  // Resolved {oe, out} per port
  wire [15:0] tx_res;
  wire [15:0] mg_res;
  wire [7:0]  tx_per_out; // Transmit peripheral data in pin order
  wire [7:0]  mg_per_out;
  wire [7:0]  mg_per_oe;

  // Bit 7 of receive port is never in the mask, so it stays general I/O
  assign rx_own = rx_mii_sel ? `PPFM_RX_OWN_MASK : `PPFM_ZERO8;
  assign tx_own = tx_mii_sel ? `PPFM_TX_OWN_MASK : `PPFM_ZERO8;
  assign mg_own = mg_mii_sel ? `PPFM_MG_OWN_MASK : `PPFM_ZERO8;

  // Transmit: error, enable, clock input (undriven), four data bits
  assign tx_per_out = {1'b0, mac_tx_er, mac_tx_en, 1'b0, mac_txd};
  // Management: collision and sense are inputs, data bidirectional, clock out
  assign mg_per_out = {4'h0, 2'b00, mac_mdio_out, mac_mdc};
  assign mg_per_oe  = `PPFM_MG_PER_OE_FIX | {6'h00, mac_mdio_oe, 1'b0};

  assign rx_res = resolve(rx_own, `PPFM_ZERO8, `PPFM_RX_PER_OE, rx_gpio_data, rx_gpio_dir,
                          rx_open_drain_cfg);
  assign tx_res = resolve(tx_own, tx_per_out, `PPFM_TX_PER_OE, {1'b0, tx_gpio_data},
                          {1'b0, tx_gpio_dir}, {1'b0, tx_open_drain_cfg});
  assign mg_res = resolve(mg_own, mg_per_out, mg_per_oe, {4'h0, mg_gpio_data},
                          {4'h0, mg_gpio_dir}, {4'h0, mg_open_drain_cfg});

  // Pad drive, pull and read-back registers
  always @(posedge sys_clk) begin
    if (rst) begin
      // General I/O inputs, no pulls, full drive
      rx_pin_out     <= `PPFM_ZERO8;
      rx_pin_oe      <= `PPFM_ZERO8;
      rx_pad_reduce  <= `PPFM_ZERO8;
      rx_pad_pull_en <= `PPFM_ZERO8;
      rx_pad_pull_up <= `PPFM_ZERO8;
      rx_pin_value   <= `PPFM_ZERO8;
      tx_pin_out     <= `PPFM_ZERO7;
      tx_pin_oe      <= `PPFM_ZERO7;
      tx_pad_reduce  <= `PPFM_ZERO7;
      tx_pad_pull_en <= `PPFM_ZERO7;
      tx_pad_pull_up <= `PPFM_ZERO7;
      tx_pin_value   <= `PPFM_ZERO7;
      mg_pin_out     <= `PPFM_ZERO4;
      mg_pin_oe      <= `PPFM_ZERO4;
      mg_pad_reduce  <= `PPFM_ZERO4;
      mg_pad_pull_en <= `PPFM_ZERO4;
      mg_pad_pull_up <= `PPFM_ZERO4;
      mg_pin_value   <= `PPFM_ZERO4;
    end else begin
      rx_pin_out     <= rx_res[7:0];
      rx_pin_oe      <= rx_res[15:8];
      tx_pin_out     <= tx_res[6:0];
      tx_pin_oe      <= tx_res[14:8];
      mg_pin_out     <= mg_res[3:0];
      mg_pin_oe      <= mg_res[11:8];
      // Two drive strengths, chosen per pin
      rx_pad_reduce  <= rx_reduce_cfg;
      tx_pad_reduce  <= tx_reduce_cfg;
      mg_pad_reduce  <= mg_reduce_cfg;
      // Pull only while the pin is not driven, so it never fights the driver
      rx_pad_pull_en <= rx_pull_en_cfg & ~rx_res[15:8];
      tx_pad_pull_en <= tx_pull_en_cfg & ~tx_res[14:8];
      mg_pad_pull_en <= mg_pull_en_cfg & ~mg_res[11:8];
      rx_pad_pull_up <= rx_pull_up_cfg;
      tx_pad_pull_up <= tx_pull_up_cfg;
      mg_pad_pull_up <= mg_pull_up_cfg;
      // Pin level stays readable whoever owns the pin
      rx_pin_value   <= rx_pin_in;
      tx_pin_value   <= tx_pin_in;
      mg_pin_value   <= mg_pin_in;
    end
  end

  // Controller-side inputs: zero unless the interface owns the pins
  // Limitation: media clocks pass through one flop, so they are resampled at sys_clk
  always @(posedge sys_clk) begin
    if (rst) begin
      mac_rxd     <= `PPFM_ZERO4;
      mac_rx_dv   <= 1'b0;
      mac_rx_er   <= 1'b0;
      mac_rx_clk  <= 1'b0;
      mac_tx_clk  <= 1'b0;
      mac_col     <= 1'b0;
      mac_crs     <= 1'b0;
      mac_mdio_in <= 1'b0;
    end else begin
      mac_rxd     <= rx_pin_in[3:0] & {4{rx_mii_sel}};
      mac_rx_dv   <= rx_pin_in[`PPFM_RX_DV_BIT] & rx_mii_sel;
      mac_rx_er   <= rx_pin_in[`PPFM_RX_ER_BIT] & rx_mii_sel;
      mac_rx_clk  <= rx_pin_in[`PPFM_RX_CLK_BIT] & rx_mii_sel;
      mac_tx_clk  <= tx_pin_in[`PPFM_TX_CLK_BIT] & tx_mii_sel;
      mac_col     <= mg_pin_in[`PPFM_MG_COL_BIT] & mg_mii_sel;
      mac_crs     <= mg_pin_in[`PPFM_MG_CRS_BIT] & mg_mii_sel;
      mac_mdio_in <= mg_pin_in[`PPFM_MG_MDIO_BIT] & mg_mii_sel;
    end
  end

  // Wake-up interrupt per port, independent of peripheral ownership
  ppfm_irq_filter #(.W(`PPFM_RX_W)) u_rx_irq (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_raw  (rx_pin_in),
    .pull_up  (rx_pull_up_cfg),
    .irq_en   (rx_irq_en),
    .flag_clr (rx_flag_clr),
    .flag     (rx_irq_flag),
    .irq      (rx_irq)
  );

  ppfm_irq_filter #(.W(`PPFM_TX_W)) u_tx_irq (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_raw  (tx_pin_in),
    .pull_up  (tx_pull_up_cfg),
    .irq_en   (tx_irq_en),
    .flag_clr (tx_flag_clr),
    .flag     (tx_irq_flag),
    .irq      (tx_irq)
  );

  ppfm_irq_filter #(.W(`PPFM_MG_W)) u_mg_irq (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_raw  (mg_pin_in),
    .pull_up  (mg_pull_up_cfg),
    .irq_en   (mg_irq_en),
    .flag_clr (mg_flag_clr),
    .flag     (mg_irq_flag),
    .irq      (mg_irq)
  );

endmodule // ppfm_port_mux

// *** verification/ppfm_pad_far.sv ***
// Purpose: Pads and far-side drivers of one port
// Assumes: Pad wins over an external driver
// Notes:   A line nobody drives or pulls toggles every cycle
`timescale 1ns/1ps
module ppfm_pad_far #(
  parameter N = 8
) (
  input  wire [N-1:0] o, oe, pe, pu, dv, de,
  input  wire         flt,
  output wire [N-1:0] pin
);
  // Released open-drain lines fall to pull or external level
  assign pin = (oe & o) | (~oe & de & dv) | (~oe & ~de & pe & pu)
    | (~oe & ~de & ~pe & {N{flt}});
endmodule // ppfm_pad_far

// *** verification/ppfm_port_mux_chk.sv ***
// Purpose: Concurrent checks on the pin function multiplexer ports
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into ppfm_port_mux from the bench top
`timescale 1ns/1ps
module ppfm_port_mux_chk (
  input wire       sys_clk, rst, rx_mii_sel, tx_mii_sel, mg_mii_sel,
  input wire       mac_rx_dv, mac_tx_en, mac_tx_clk, mac_mdio_oe,
  input wire [7:0] rx_pin_in, rx_pin_oe, rx_gpio_data, rx_gpio_dir, rx_open_drain_cfg, rx_irq_flag,
  input wire [6:0] tx_pin_in, tx_pin_out, tx_pin_oe, tx_pad_reduce, tx_pad_pull_en,
  input wire [6:0] tx_gpio_data, tx_gpio_dir, tx_reduce_cfg, tx_pull_en_cfg, tx_open_drain_cfg,
  input wire [3:0] mg_pin_oe, mg_open_drain_cfg, mac_rxd
);
  // One domain, so reset masks every check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_rst_idle: assert property (
    $past(rst) |-> ~|{rx_pin_oe, tx_pin_oe, mg_pin_oe, rx_irq_flag})
    else $error("pins busy after reset");
  chk_tx_en_pin: assert property (
    tx_mii_sel && !tx_open_drain_cfg[5] |=> tx_pin_oe[5] && tx_pin_out[5] == $past(mac_tx_en))
    else $error("transmit enable pin wrong");
  chk_tx_clk_in: assert property (
    tx_mii_sel |=> !tx_pin_oe[4] && mac_tx_clk == $past(tx_pin_in[4]))
    else $error("transmit clock pin wrong");
  chk_rx_owned_in: assert property (
    rx_mii_sel |=> rx_pin_oe[6:0] == 7'h00 && mac_rxd == $past(rx_pin_in[3:0]) && mac_rx_dv == $past(rx_pin_in[5]))
    else $error("receive pins wrong");
  chk_rx_top_gpio: assert property (
    rx_mii_sel |=> rx_pin_oe[7] == $past(rx_gpio_dir[7] & ~(rx_open_drain_cfg[7] & rx_gpio_data[7])))
    else $error("receive top pin not general I/O");
  chk_gpio_fallback: assert property (
    !tx_mii_sel |=> tx_pin_oe == $past(tx_gpio_dir & ~(tx_open_drain_cfg & tx_gpio_data))
      && tx_pin_out == $past(tx_gpio_data & ~tx_open_drain_cfg))
    else $error("general I/O drive wrong");
  chk_mdio_dir: assert property (
    mg_mii_sel && mg_open_drain_cfg == 4'h0 |=> mg_pin_oe == {2'h0, $past(mac_mdio_oe), 1'h1})
    else $error("management pin direction wrong");
  chk_pull_drive: assert property (
    !$past(rst) |-> tx_pad_reduce == $past(tx_reduce_cfg)
      && tx_pad_pull_en == ($past(tx_pull_en_cfg) & ~tx_pin_oe))
    else $error("pad drive or pull wrong");
  // A flag may only follow a level that stayed put for several samples
  chk_filter_hold: assert property (
    $rose(rx_irq_flag[0]) |-> $past(rx_pin_in[0], 2) == $past(rx_pin_in[0], 3))
    else $error("flag set by a glitch");
  cov_tx_owned: cover property (tx_mii_sel ##1 tx_pin_oe[5]);
  cov_mdio_drive: cover property (mg_mii_sel && mac_mdio_oe);
  cov_flag_set: cover property ($rose(rx_irq_flag[0]));
endmodule // ppfm_port_mux_chk

// *** verification/tb_ppfm_port_mux.sv ***
// Purpose: Random and corner tests of the pin function multiplexer
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected values come from bench functions only
`timescale 1ns/1ps
module tb_ppfm_port_mux;
  logic sys_clk = 0, rst = 1, flt = 0;
  logic rx_mii_sel, tx_mii_sel, mg_mii_sel, mac_tx_en, mac_tx_er, mac_mdio_out, mac_mdio_oe, mac_mdc;
  logic [3:0] mac_txd;
  logic [7:0] rx_gpio_data, rx_gpio_dir, rx_reduce_cfg, rx_pull_en_cfg, rx_pull_up_cfg, rx_open_drain_cfg;
  logic [7:0] rx_irq_en, rx_flag_clr, rx_drv, rx_de;
  logic [6:0] tx_gpio_data, tx_gpio_dir, tx_reduce_cfg, tx_pull_en_cfg, tx_pull_up_cfg, tx_open_drain_cfg;
  logic [6:0] tx_irq_en, tx_flag_clr, tx_drv, tx_de;
  logic [3:0] mg_gpio_data, mg_gpio_dir, mg_reduce_cfg, mg_pull_en_cfg, mg_pull_up_cfg, mg_open_drain_cfg;
  logic [3:0] mg_irq_en, mg_flag_clr, mg_drv, mg_de;
  wire [7:0] rx_pin_in, rx_pin_out, rx_pin_oe, rx_pad_reduce, rx_pad_pull_en, rx_pad_pull_up, rx_pin_value, rx_irq_flag;
  wire [6:0] tx_pin_in, tx_pin_out, tx_pin_oe, tx_pad_reduce, tx_pad_pull_en, tx_pad_pull_up, tx_pin_value, tx_irq_flag;
  wire [3:0] mg_pin_in, mg_pin_out, mg_pin_oe, mg_pad_reduce, mg_pad_pull_en, mg_pad_pull_up, mg_pin_value, mg_irq_flag;
  wire [3:0] mac_rxd;
  wire rx_irq, tx_irq, mg_irq, mac_rx_dv, mac_rx_er, mac_rx_clk, mac_tx_clk, mac_col, mac_crs, mac_mdio_in;
  // Bit 0 flags and port requests of all three ports, as one word
  wire [5:0] irq_obs = {rx_irq_flag[0], tx_irq_flag[0], mg_irq_flag[0], rx_irq, tx_irq, mg_irq};
  int n_tests = 0, n_mismatch = 0;
  logic [15:0] ex [0:8];
  ppfm_port_mux dut (.*);
  ppfm_pad_far #(.N(8)) rx_pad (.o(rx_pin_out), .oe(rx_pin_oe), .pe(rx_pad_pull_en), .pu(rx_pad_pull_up),
    .dv(rx_drv), .de(rx_de), .flt(flt), .pin(rx_pin_in));
  ppfm_pad_far #(.N(7)) tx_pad (.o(tx_pin_out), .oe(tx_pin_oe), .pe(tx_pad_pull_en), .pu(tx_pad_pull_up),
    .dv(tx_drv), .de(tx_de), .flt(flt), .pin(tx_pin_in));
  ppfm_pad_far #(.N(4)) mg_pad (.o(mg_pin_out), .oe(mg_pin_oe), .pe(mg_pad_pull_en), .pu(mg_pad_pull_up),
    .dv(mg_drv), .de(mg_de), .flt(flt), .pin(mg_pin_in));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) flt <= ~flt;
  // Owned bits follow the peripheral; open drain never drives high
  function automatic [15:0] exp_pin(input s, input [7:0] own, poe, pout, gdir, gdat, od);
    logic [7:0] d, v;
    d = s ? (own & poe) | (~own & gdir) : gdir;
    v = s ? (own & pout) | (~own & gdat) : gdat;
    return {v & ~od, d & ~(od & v)};
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rnd(input int i);
    {rx_gpio_data, rx_gpio_dir, rx_reduce_cfg, rx_pull_en_cfg} = $urandom;
    {rx_pull_up_cfg, rx_open_drain_cfg, rx_irq_en, rx_drv} = $urandom;
    {tx_gpio_data, tx_gpio_dir, tx_reduce_cfg, tx_pull_en_cfg} = $urandom;
    {tx_pull_up_cfg, tx_open_drain_cfg, tx_irq_en, tx_drv} = $urandom;
    {mg_gpio_data, mg_gpio_dir, mg_reduce_cfg, mg_pull_en_cfg, mg_pull_up_cfg, mg_open_drain_cfg, mg_irq_en,
      mg_drv} = $urandom;
    {rx_flag_clr, tx_flag_clr, rx_de, tx_de, mg_de} = $urandom;
    {mg_flag_clr, rx_mii_sel, tx_mii_sel, mg_mii_sel, mac_txd, mac_tx_en, mac_tx_er, mac_mdio_out, mac_mdio_oe,
      mac_mdc} = $urandom;
    // Corners: every pin open drain; every port selected while general I/O asks to drive
    if (i % 8 == 1) {rx_open_drain_cfg, tx_open_drain_cfg, mg_open_drain_cfg} = 19'h7FFFF;
    if (i % 8 == 2) {rx_mii_sel, tx_mii_sel, mg_mii_sel, rx_gpio_dir, tx_gpio_dir, mg_gpio_dir} = 22'h3FFFFF;
  endtask
  // Pin levels now are what the next edge registers
  task automatic snap;
    ex[0] = exp_pin(rx_mii_sel, 8'h7F, 8'h00, 8'h00, rx_gpio_dir, rx_gpio_data, rx_open_drain_cfg);
    ex[1] = exp_pin(tx_mii_sel, 8'h7F, 8'h6F, {1'h0, mac_tx_er, mac_tx_en, 1'h0, mac_txd}, {1'h0, tx_gpio_dir},
      {1'h0, tx_gpio_data}, {1'h0, tx_open_drain_cfg});
    ex[2] = exp_pin(mg_mii_sel, 8'h0F, {6'h00, mac_mdio_oe, 1'h1}, {6'h00, mac_mdio_out, mac_mdc},
      {4'h0, mg_gpio_dir}, {4'h0, mg_gpio_data}, {4'h0, mg_open_drain_cfg});
    ex[3] = {rx_mii_sel ? rx_pin_in[6:0] : 7'h00, tx_mii_sel & tx_pin_in[4], mg_mii_sel ? mg_pin_in[3:1] : 3'h0, 5'h00};
    ex[4] = {rx_pin_in, 1'h0, tx_pin_in};
    ex[5] = {rx_reduce_cfg, rx_pull_en_cfg & ~ex[0][7:0]};
    ex[6] = {1'h0, tx_pull_up_cfg, 1'h0, tx_pull_en_cfg & ~ex[1][6:0]};
    ex[7] = {mg_pin_in, mg_reduce_cfg, mg_pull_up_cfg, mg_pull_en_cfg & ~ex[2][3:0]};
    ex[8] = {rx_pull_up_cfg, 1'h0, tx_reduce_cfg};
  endtask
  task automatic cmp;
    chk({rx_pin_out, rx_pin_oe}, ex[0]);
    chk({1'h0, tx_pin_out, 1'h0, tx_pin_oe}, ex[1]);
    chk({4'h0, mg_pin_out, 4'h0, mg_pin_oe}, ex[2]);
    chk({mac_rx_er, mac_rx_dv, mac_rx_clk, mac_rxd, mac_tx_clk, mac_col, mac_crs, mac_mdio_in, 5'h00}, ex[3]);
    chk({rx_pin_value, 1'h0, tx_pin_value}, ex[4]);
    chk({rx_pad_reduce, rx_pad_pull_en}, ex[5]);
    chk({1'h0, tx_pad_pull_up, 1'h0, tx_pad_pull_en}, ex[6]);
    chk({mg_pin_value, mg_pad_reduce, mg_pad_pull_up, mg_pad_pull_en}, ex[7]);
    chk({rx_pad_pull_up, 1'h0, tx_pad_reduce}, ex[8]);
  endtask
  // Settle at idle level, pulse bit 0 of all ports, then check and clear the flags
  task automatic pulse(input int len, input logic pu, en, ef);
    {rx_mii_sel, tx_mii_sel, mg_mii_sel, rx_gpio_dir, tx_gpio_dir, mg_gpio_dir} = 22'h000000;
    {rx_de, tx_de, mg_de, rx_flag_clr, tx_flag_clr, mg_flag_clr} = 38'h3FFFFFFFFF;
    {rx_pull_up_cfg, rx_drv, tx_pull_up_cfg, tx_drv, mg_pull_up_cfg, mg_drv} = {38{pu}};
    {rx_irq_en, tx_irq_en, mg_irq_en} = {19{en}};
    repeat (8) @(posedge sys_clk);
    #1 {rx_flag_clr, tx_flag_clr, mg_flag_clr} = 19'h00000;
    {rx_drv[0], tx_drv[0], mg_drv[0]} = {3{~pu}};
    repeat (len) @(posedge sys_clk);
    #1 {rx_drv[0], tx_drv[0], mg_drv[0]} = {3{pu}};
    // Flag must already follow the pulse edge, before the return edge is filtered in
    chk({10'h000, irq_obs}, {10'h000, {6{ef}}});
    repeat (6) @(posedge sys_clk);
    #1 chk({10'h000, irq_obs}, {10'h000, {6{ef}}});
    {rx_flag_clr[0], tx_flag_clr[0], mg_flag_clr[0]} = 3'h7;
    repeat (2) @(posedge sys_clk);
    #1 chk({10'h000, irq_obs}, 16'h0000);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is about 165 cycles; this bound of 3000 cycles is some eighteen times that
  initial begin
    #(25 * 3000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(72));
    rnd(0);
    repeat (4) @(posedge sys_clk);
    #1 chk({rx_pin_oe, rx_pin_out}, 16'h0000);
    chk({tx_pin_oe, mg_pin_oe, rx_pad_pull_en[4:0]}, 16'h0000);
    chk({rx_irq_flag, rx_pad_reduce}, 16'h0000);
    rst = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      #1 if (i > 0) cmp();
      rnd(i);
      #1 snap();
    end
    // Last random set is checked too, and the pulses start on the usual offset
    @(posedge sys_clk);
    #1 cmp();
    pulse(2, 1'h0, 1'h1, 1'h0);
    pulse(4, 1'h0, 1'h1, 1'h1);
    pulse(5, 1'h0, 1'h0, 1'h0);
    pulse(1, 1'h1, 1'h1, 1'h0);
    pulse(3, 1'h1, 1'h1, 1'h1);
    tally_and_finish();
  end
endmodule // tb_ppfm_port_mux
bind ppfm_port_mux ppfm_port_mux_chk u_chk (.*);
